// >>> core/av_presence_irq_pkg.sv
/*
 * Constants and carrier types of the audio/video presence interrupt block.
 * Assumes a single 100 MHz clock and an active-low asynchronous reset.
 */
//
// Overview of operation
// - The pin requests only while pin enable bit 5 is 1; it resets to 0.
// - Edge bit 4 picks a falling (0) or rising (1) request held till cleared.
// - Audio event mode bits 3-2 pick none, appear, disappear or both, reset 3.
// - Video event mode bits 1-0 pick none, appear, disappear or both, reset 3.
// - Mask bits 0-3 gate video inputs 1-4, bits 4-7 audio 1-4; reset FFh.
// - A cleared enable bit stops status updates and requests of its input.
// - Aux control bit 0 gates the fifth audio input, reset 0 meaning disabled.
// - Status holds one activated bit per input in mask order; reset 00h.
// - A status bit is set only for events picked by the matching mode field.
// - The fifth audio state is bit 0 of its own status register, reset 0.
// - A 7-bit part id spans two locations above a 3-bit revision; the high one also holds 3 writable test bits.
// - Audio is present above threshold; method resets to differential.
// - Audio inputs 1-4 have a five-bit threshold with its top bit held apart; input 5 keeps all five bits together.
package av_presence_irq_pkg;

    // ********************************************************
    // register offsets
    // ********************************************************
    localparam logic [7:0] ADDR_THR_MSB   = 8'hE1;
    localparam logic [7:0] ADDR_THR_12    = 8'hE2;
    localparam logic [7:0] ADDR_THR_34    = 8'hE3;
    localparam logic [7:0] ADDR_THR_5     = 8'hE4;
    localparam logic [7:0] ADDR_IRQ_CTL   = 8'hFB;
    localparam logic [7:0] ADDR_AUX_CTL   = 8'h73;
    localparam logic [7:0] ADDR_STAT5     = 8'h74;
    localparam logic [7:0] ADDR_MASK      = 8'hFC;
    localparam logic [7:0] ADDR_STATUS    = 8'hFD;
    localparam logic [7:0] ADDR_ID_HIGH   = 8'hFE;
    localparam logic [7:0] ADDR_ID_LOW    = 8'hFF;

    // ********************************************************
    // field positions
    // ********************************************************
    localparam int IRQ_ENA_BIT   = 5;
    localparam int IRQ_EDGE_BIT  = 4;
    localparam int METHOD_BIT    = 7;
    localparam int AUX_FORM_BIT  = 2;
    localparam int AUX_PTEST_BIT = 1;
    localparam int AUX_EN5_BIT   = 0;

    // ********************************************************
    // reset values
    // ********************************************************
    localparam logic [5:0] IRQ_CTL_RST = 6'h0F;
    localparam logic [7:0] MASK_RST    = 8'hFF;
    localparam logic [7:0] STATUS_RST  = 8'h00;
    localparam logic [2:0] AUX_RST     = 3'h0;
    localparam logic [4:0] THR_RST     = 5'h03;
    localparam logic [2:0] FILT_RST    = 3'h7;
    localparam logic       METHOD_RST  = 1'b1;

    typedef logic [4:0] level_type;

    // presence inputs from the analog detectors
    typedef struct packed {
        logic [3:0]           video;
        logic [4:0][4:0]      abs_amp;
        logic [4:0][4:0]      diff_amp;
    } detect_in_type;

    // register port request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_type;

endpackage

// >>> core/av_presence_irq_ctrl.sv
/*
 * Presence event collector with mask, status and one interrupt pin,
 * plus identifier registers. Assumes detector inputs and register
 * requests come from logic on the same clock.
 */
`timescale 1ns/1ps
module av_presence_irq_ctrl #(
    parameter logic [6:0] PART_ID  = 7'h2A,  // arbitrary value
    parameter logic [2:0] REVISION = 3'h5    // arbitrary value
) (
    // clock and reset
    input  wire logic                               clk_i,
    input  wire logic                               resetn_i,
    // detector inputs
    input  wire av_presence_irq_pkg::detect_in_type det_i,
    // register port
    input  wire av_presence_irq_pkg::reg_req_type   req_i,
    output logic [7:0]                              rdata_o,
    // interrupt pin
    output logic                                    irq_o
);
    import av_presence_irq_pkg::*;

    typedef struct packed {
        logic [5:0]      ctl;
        logic [7:0]      mask;
        logic [2:0]      aux;
        logic [7:0]      status;
        logic            stat5;
        logic [2:0]      test;
        logic            method;
        logic [2:0]      filt;
        logic [4:0][4:0] thr;
        logic [3:0]      v_prev;
        logic [4:0]      a_prev;
        logic [7:0]      rdata;
        logic            irq;
    } state_type;

    state_type state_reg;
    state_type state_next;
    logic [4:0] audio_now;
    logic [8:0] rise;
    logic [8:0] fall;
    logic [8:0] ev;
    logic       pending;

    // edge events picked by a two-bit mode: bit0 appear, bit1 disappear
    function automatic logic pick(input logic [1:0] mode, input logic r,
                                  input logic f);
        pick = (mode[0] & r) | (mode[1] & f);
    endfunction

    // ********************************************************
    // read decode
    // ********************************************************
    function automatic logic [7:0] read_mux(input state_type s,
                                            input logic [7:0] a);
        logic [7:0] t;
        t = 8'h00;
        case (a)
            ADDR_IRQ_CTL: t = {2'b00, s.ctl};
            ADDR_MASK:    t = s.mask;
            ADDR_STATUS:  t = s.status;
            ADDR_AUX_CTL: t = {5'b00000, s.aux};
            ADDR_STAT5:   t = {7'b0000000, s.stat5};
            ADDR_ID_HIGH: t = {PART_ID[6:5], 3'b000, s.test};
            ADDR_ID_LOW:  t = {PART_ID[4:0], REVISION};
            ADDR_THR_MSB: t = {s.method, s.filt, s.thr[3][4], s.thr[2][4],
                               s.thr[1][4], s.thr[0][4]};
            ADDR_THR_12:  t = {s.thr[1][3:0], s.thr[0][3:0]};
            ADDR_THR_34:  t = {s.thr[3][3:0], s.thr[2][3:0]};
            ADDR_THR_5:   t = {3'b000, s.thr[4]};
            default:      t = 8'h00;   // unmapped reads as zero
        endcase
        return t;
    endfunction

    // ********************************************************
    // presence detection and edges
    // ********************************************************
    // absolute or differential amplitude against each threshold
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            audio_now[i] = (state_reg.method ? det_i.diff_amp[i]
                                             : det_i.abs_amp[i])
                           > state_reg.thr[i];
        end
    end

    assign rise = {audio_now & ~state_reg.a_prev,
                   det_i.video & ~state_reg.v_prev};
    assign fall = {~audio_now & state_reg.a_prev,
                   ~det_i.video & state_reg.v_prev};

    // per-input event, gated by its own enable
    always_comb begin
        for (int i = 0; i < 9; i++) begin
            if (i < 4) begin
                ev[i] = pick(state_reg.ctl[1:0], rise[i], fall[i]);
            end else begin
                ev[i] = pick(state_reg.ctl[3:2], rise[i], fall[i]);
            end
        end
        ev[7:0] = ev[7:0] & state_reg.mask;
        ev[8]   = ev[8] & state_reg.aux[AUX_EN5_BIT];
    end

    // only enabled, activated bits hold the pin
    assign pending = |(state_reg.status & state_reg.mask)
                   | (state_reg.stat5 & state_reg.aux[AUX_EN5_BIT]);

    // ********************************************************
    // next state
    // ********************************************************
    always_comb begin
        state_next = state_reg;
        state_next.v_prev = det_i.video;
        state_next.a_prev = audio_now;
        if (req_i.rd) begin
            state_next.rdata = read_mux(state_reg, req_i.addr);
        end
        if (req_i.wr) begin
            case (req_i.addr)
                ADDR_IRQ_CTL: state_next.ctl = req_i.wdata[5:0];
                ADDR_MASK:    state_next.mask = req_i.wdata;
                ADDR_AUX_CTL: state_next.aux = req_i.wdata[2:0];
                ADDR_STATUS:  state_next.status = state_reg.status
                                                  & ~req_i.wdata;
                ADDR_STAT5:   state_next.stat5 = state_reg.stat5
                                                 & ~req_i.wdata[0];
                ADDR_ID_HIGH: state_next.test = req_i.wdata[2:0];
                ADDR_THR_MSB: begin
                    state_next.method = req_i.wdata[METHOD_BIT];
                    state_next.filt   = req_i.wdata[6:4];
                    for (int i = 0; i < 4; i++) begin
                        state_next.thr[i][4] = req_i.wdata[i];
                    end
                end
                ADDR_THR_12: begin
                    state_next.thr[0][3:0] = req_i.wdata[3:0];
                    state_next.thr[1][3:0] = req_i.wdata[7:4];
                end
                ADDR_THR_34: begin
                    state_next.thr[2][3:0] = req_i.wdata[3:0];
                    state_next.thr[3][3:0] = req_i.wdata[7:4];
                end
                ADDR_THR_5:   state_next.thr[4] = req_i.wdata[4:0];
                default:      state_next.ctl = state_reg.ctl;
            endcase
        end
        // set after clear so a same-cycle event is never lost
        state_next.status = state_next.status | ev[7:0];
        state_next.stat5  = state_next.stat5 | ev[8];
        // pin level: requesting level chosen by edge select
        state_next.irq = (state_reg.ctl[IRQ_ENA_BIT] & pending)
                         ~^ state_reg.ctl[IRQ_EDGE_BIT];
    end

    // ********************************************************
    // state register
    // ********************************************************
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_reg        <= '0;
            state_reg.ctl    <= IRQ_CTL_RST;
            state_reg.mask   <= MASK_RST;
            state_reg.status <= STATUS_RST;
            state_reg.aux    <= AUX_RST;
            state_reg.method <= METHOD_RST;
            state_reg.filt   <= FILT_RST;
            state_reg.thr    <= {5{THR_RST}};
            state_reg.irq    <= 1'b1;   // idle high while edge select is 0
        end else begin
            state_reg <= state_next;
        end
    end

    assign rdata_o = state_reg.rdata;
    assign irq_o   = state_reg.irq;

    // ********************************************************
    // checks
    // ********************************************************
    // all checks run on the one clock and sleep through reset
    default clocking cb_main @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);

    a_pin_disabled_idle: assert property (
        !state_reg.ctl[IRQ_ENA_BIT] |=>
        irq_o == !$past(state_reg.ctl[IRQ_EDGE_BIT]))
        else $error("pin requested while disabled");
    a_pin_request_level: assert property (
        (state_reg.ctl[IRQ_ENA_BIT] && pending) |=>
        irq_o == $past(state_reg.ctl[IRQ_EDGE_BIT]))
        else $error("pin not at requesting level");
    a_audio_mode_none: assert property (
        (state_reg.ctl[3:2] == 2'b00) |-> ev[8:4] == 5'b00000)
        else $error("audio event with mode none");
    a_video_appear_only: assert property (
        (state_reg.ctl[1:0] == 2'b01) |-> (ev[3:0] & ~rise[3:0]) == 4'h0)
        else $error("video event other than appear");
    a_masked_no_update: assert property (
        (!state_reg.mask[0] && !state_reg.status[0]) |=>
        !state_reg.status[0])
        else $error("masked status bit was set");
    a_fifth_gated: assert property (
        (!state_reg.aux[AUX_EN5_BIT] && !state_reg.stat5) |=>
        !state_reg.stat5)
        else $error("fifth audio state set while disabled");
    a_event_sets_status: assert property (
        ev[7:0] != 8'h00 |=>
        (state_reg.status & $past(ev[7:0])) == $past(ev[7:0]))
        else $error("event did not set status");
    a_fifth_sets_state: assert property (
        ev[8] |=> state_reg.stat5)
        else $error("fifth audio event lost");
    a_id_readback: assert property (
        (req_i.rd && req_i.addr == ADDR_ID_LOW) |=>
        rdata_o == {PART_ID[4:0], REVISION})
        else $error("identifier read wrong");
    a_audio_compare: assert property (
        (state_reg.method && det_i.diff_amp[0] > state_reg.thr[0]) |->
        audio_now[0])
        else $error("audio presence compare wrong");
endmodule

// >>> verification/host_model.sv
/*
 * Host processor model: single byte register writes and reads.
 * Assumes clk_i from the bench and read data one cycle after rd.
 */
`timescale 1ns/1ps
module host_model (
    // clock
    input  wire logic                        clk_i,
    // register port
    output av_presence_irq_pkg::reg_req_type req_o,
    input  wire logic [7:0]                  rdata_i
);
    import av_presence_irq_pkg::*;

    initial req_o = '0;

    // request held across one sampling edge, then released
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        // test fields stay clear in normal use
        if (a == ADDR_ID_HIGH) v[2:0] = 3'h0;
        if (a == ADDR_AUX_CTL) v[AUX_PTEST_BIT] = 1'b0;
        @(posedge clk_i);
        #1 req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(posedge clk_i);
        #1 req_o.wr = 1'b0;
        req_o.wdata = ~v;  // stale data is not left on the port
    endtask

    // data taken just after the edge that follows the read edge
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        #1 req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk_i);
        #1 req_o.rd = 1'b0;
        d = rdata_i;
    endtask
endmodule

// >>> verification/testbench.sv
/*
 * Self-checking bench of the presence interrupt block.
 * Assumes the host model drives the register port.
 */
`timescale 1ns/1ps
module testbench;
    import av_presence_irq_pkg::*;
    localparam logic [6:0] ID  = 7'h2A;  // arbitrary value
    localparam logic [2:0] REV = 3'h5;   // arbitrary value
    logic          clk_i = 1'b0;
    logic          resetn_i = 1'b0;
    detect_in_type det = '0;
    reg_req_type   req;
    logic [7:0]    rdata_o;
    logic          irq_o;
    int            n_fail = 0;
    int            tests_run = 0;
    logic [3:0]    vid;
    logic [3:0]    exp_v;
    logic [7:0]    msk;

    // ****************************************
    // clock, design and host
    // ****************************************
    always #5 clk_i = ~clk_i;
    av_presence_irq_ctrl #(.PART_ID(ID), .REVISION(REV)) dut (
        .clk_i(clk_i), .resetn_i(resetn_i), .det_i(det),
        .req_i(req), .rdata_o(rdata_o), .irq_o(irq_o));
    host_model h (.clk_i(clk_i), .req_o(req), .rdata_i(rdata_o));

    // ****************************************
    // helpers
    // ****************************************
    task automatic check(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] v;
        h.read_reg(a, v);
        check(v, e);
    endtask
    // status expected after one appear (a=1) or disappear event of
    // video input two and audio input one under event mode m
    function automatic logic [7:0] mode_exp(input logic [1:0] m,
                                            input logic a);
        logic hit;
        hit = a ? m[0] : m[1];
        return {3'h0, hit, 2'h0, hit, 1'b0};
    endfunction
    // event edge, status, then pin: three edges cover it
    task automatic settle();
        repeat (3) @(posedge clk_i);
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ****************************************
    // watchdog, far above the expected run time
    // ****************************************
    initial begin
        #200000;
        n_fail++;
        print_verdict();
    end

    // ****************************************
    // tests
    // ****************************************
    initial begin
        void'($urandom(32'h012debf7));
        repeat (10) @(posedge clk_i);
        #1 resetn_i = 1'b1;
        rchk(ADDR_IRQ_CTL, 8'h0F);
        rchk(ADDR_MASK, 8'hFF);
        rchk(ADDR_STATUS, 8'h00);
        rchk(ADDR_AUX_CTL, 8'h00);
        rchk(ADDR_STAT5, 8'h00);
        rchk(ADDR_ID_HIGH, {ID[6:5], 6'h00});
        rchk(ADDR_ID_LOW, {ID[4:0], REV});
        rchk(8'h10, 8'h00);
        $display("test reset values done");
        // pin disabled, then falling request, then rising request
        @(posedge clk_i);
        #1 det.video = 4'h1;
        settle();
        rchk(ADDR_STATUS, 8'h01);
        check({7'h0, irq_o}, 8'h01);
        h.write_reg(ADDR_IRQ_CTL, 8'h2F);
        settle();
        check({7'h0, irq_o}, 8'h00);
        h.write_reg(ADDR_IRQ_CTL, 8'h3F);
        settle();
        check({7'h0, irq_o}, 8'h01);
        h.write_reg(ADDR_STATUS, 8'h01);
        settle();
        check({7'h0, irq_o}, 8'h00);
        $display("test pin control done");
        // masked input does not set status
        h.write_reg(ADDR_MASK, 8'hFE);
        @(posedge clk_i);
        #1 det.video = 4'h0;
        settle();
        rchk(ADDR_STATUS, 8'h00);
        h.write_reg(ADDR_MASK, 8'hFF);
        $display("test mask done");
        // every mode code for video input two and audio input one
        for (int m = 0; m < 4; m++) begin
            h.write_reg(ADDR_IRQ_CTL, {4'h0, m[1:0], m[1:0]});
            @(posedge clk_i);
            #1 det.video[1] = 1'b1;
            det.diff_amp[0] = 5'h09;
            settle();
            rchk(ADDR_STATUS, mode_exp(m[1:0], 1'b1));
            h.write_reg(ADDR_STATUS, 8'hFF);
            @(posedge clk_i);
            #1 det.video[1] = 1'b0;
            det.diff_amp[0] = 5'h00;
            settle();
            rchk(ADDR_STATUS, mode_exp(m[1:0], 1'b0));
            h.write_reg(ADDR_STATUS, 8'hFF);
        end
        $display("test event modes done");
        // fifth audio gated by its own enable; absolute level ignored
        @(posedge clk_i);
        #1 det.diff_amp[4] = 5'h05;
        det.abs_amp[1] = 5'h1F;
        settle();
        rchk(ADDR_STAT5, 8'h00);
        rchk(ADDR_STATUS, 8'h00);
        h.write_reg(ADDR_AUX_CTL, 8'h01);
        rchk(ADDR_AUX_CTL, 8'h01);
        @(posedge clk_i);
        #1 det.diff_amp[4] = 5'h00;
        settle();
        rchk(ADDR_STAT5, 8'h01);
        h.write_reg(ADDR_STAT5, 8'h01);
        rchk(ADDR_STAT5, 8'h00);
        $display("test fifth audio done");
        // absolute method sees the loud input two; then a raised threshold
        rchk(ADDR_THR_MSB, 8'hF0);
        h.write_reg(ADDR_THR_MSB, 8'h70);
        settle();
        rchk(ADDR_STATUS, 8'h20);
        h.write_reg(ADDR_THR_MSB, 8'hF4);
        h.write_reg(ADDR_STATUS, 8'hFF);
        rchk(ADDR_THR_MSB, 8'hF4);
        @(posedge clk_i);
        #1 det.diff_amp[2] = 5'h13;
        settle();
        rchk(ADDR_STATUS, 8'h00);
        @(posedge clk_i);
        #1 det.diff_amp[2] = 5'h14;
        settle();
        rchk(ADDR_STATUS, 8'h40);
        @(posedge clk_i);
        #1 det.diff_amp[2] = 5'h00;
        h.write_reg(ADDR_THR_MSB, 8'hF0);
        settle();
        h.write_reg(ADDR_STATUS, 8'hFF);
        rchk(ADDR_STATUS, 8'h00);
        $display("test detection threshold done");
        // random video changes under a random mask
        msk = 8'($urandom());
        h.write_reg(ADDR_MASK, msk);
        for (int i = 0; i < 20; i++) begin
            vid = det.video;
            @(posedge clk_i);
            #1 det.video = 4'($urandom());
            settle();
            exp_v = (vid ^ det.video) & msk[3:0];
            rchk(ADDR_STATUS, {4'h0, exp_v});
            h.write_reg(ADDR_STATUS, 8'hFF);
        end
        $display("test random traffic done");
        // reset in mid-run brings the control defaults back
        @(posedge clk_i);
        #1 resetn_i = 1'b0;
        repeat (2) @(posedge clk_i);
        #1 resetn_i = 1'b1;
        rchk(ADDR_IRQ_CTL, 8'h0F);
        rchk(ADDR_MASK, 8'hFF);
        check({7'h0, irq_o}, 8'h01);
        $display("test mid-run reset done");
        print_verdict();
    end
endmodule
